// ==== verilog/psm_regs.svh ====
// Register offsets, field positions, reset values and timing for the power-save controller
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PSM_OSC_OFS 8'h00
`define PSM_PMD_OFS 8'h04
`define PSM_STAT_OFS 8'h08

// ----------------------------------------
// Oscillator control fields
// ----------------------------------------
`define PSM_NEWOSC_LSB 8
`define PSM_NEWOSC_MSB 10
`define PSM_COSC_LSB 0
`define PSM_COSC_MSB 2
`define PSM_LOCK_BIT 7

// ----------------------------------------
// Status fields
// ----------------------------------------
`define PSM_ST_SLEEP_BIT 0
`define PSM_ST_IDLE_BIT 1
`define PSM_ST_HOLD_BIT 2
`define PSM_ST_WSLP_BIT 4
`define PSM_ST_WIDL_BIT 5
`define PSM_ST_WWDT_BIT 6

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define PSM_PMD_RST 16'h0000
`define PSM_PMD_MASK 16'hf9ff
`define PSM_OSC_RST 3'h0
`define PSM_EXT_CLK_OK 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSM_CLK_PERIOD_NS 10
`define PSM_STARTUP_NS 20000
`define PSM_STARTUP_CYC ((`PSM_STARTUP_NS + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)

`endif

// ==== verilog/psm_pkg.sv ====
// Types shared by the power-save controller and its bench
package psm_pkg;

    // ----------------------------------------
    // Bus carriers
    // ----------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } psm_apb_req_type;

    // Clock and power enables toward the clock tree
    typedef struct packed {
        logic cpu_clk_en;
        logic sys_osc_en;
        logic fscm_en;
        logic rc_clk_en;
    } psm_clk_ctrl_type;

    // ----------------------------------------
    // Power-save operand and controller states
    // ----------------------------------------
    typedef enum logic {
        PSM_OP_SLEEP,
        PSM_OP_IDLE
    } psm_op_type;

    typedef enum logic [2:0] {
        PSM_ST_STARTUP,
        PSM_ST_RUN,
        PSM_ST_ENTER_SLEEP,
        PSM_ST_SLEEP,
        PSM_ST_IDLE
    } psm_state_type;

endpackage

// ==== verilog/psm_power_save_ctrl.sv ====
// Power-save controller: sleep/idle sequencing, start-up hold, oscillator select, module disable
//
// Behaviour
// - Unlocked write of new_osc_select requests clock switch.
// - Only power_save_instr enters sleep or idle.
// - Sleep stops clocks and halts instruction execution.
// - Idle halts CPU; peripherals keep their clock.
// - Interrupt, watchdog time-out or reset wakes device.
// - Sleep shuts down the system oscillator.
// - Fail-safe clock monitor off during sleep.
// - Low-power RC clock runs in sleep if watchdog on.
// - Watchdog count cleared just before entering sleep.
// - Sleep disables system-clocked peripherals; external-clocked may run.
// - Only individually enabled interrupt sources wake from sleep.
// - Wake resumes on oscillator active at sleep entry.
// - Hold execution about 20 us after power-up.
`timescale 1ns/1ps
`include "psm_regs.svh"

// ----------------------------------------
// Register map, 32-bit words, low 16 bits used
// ----------------------------------------
// 0x00 oscillator control:
//   10:8 new oscillator select, read/write
//   7 configuration lock, read only
//   2:0 active oscillator, read only
// 0x04 module disable:
//   15:11 timers five down to one
//   10:9 unused, read as zero
//   8 codec interface, 7 first i2c port
//   6 second uart, 5 first uart
//   4 second spi, 3 first spi
//   2 second can, 1 first can, 0 adc
// 0x08 status:
//   0 asleep, 1 idle, 2 start-up hold, read only
//   4 woke from sleep, 5 woke from idle
//   6 woken by watchdog time-out
//   Wake flags sticky, write one to clear
// Other offsets answer with an error and read zero

// ----------------------------------------
// Limits worth knowing
// ----------------------------------------
// Wake from sleep reruns the start-up hold
// Clock switch is taken as instant
// Interrupt and watchdog inputs are asynchronous

module psm_power_save_ctrl
    import psm_pkg::*;
#(
    parameter int N_IRQ = 8,
    parameter logic [15:0] EXT_CLK_OK = `PSM_EXT_CLK_OK
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire psm_apb_req_type apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic psave_valid,
    input wire psm_op_type psave_op,
    input wire logic [N_IRQ-1:0] irq_pending,
    input wire logic [N_IRQ-1:0] irq_enable,
    input wire logic wdt_timeout,
    input wire logic wdt_enabled,
    input wire logic clk_cfg_locked,
    output logic cpu_run,
    output psm_clk_ctrl_type clk_ctrl,
    output logic wdt_clear,
    output logic osc_switch_req,
    output logic [2:0] sys_osc_sel,
    output logic [15:0] periph_clk_en,
    output logic [15:0] periph_hold
);

    localparam int HOLD_CYC = `PSM_STARTUP_CYC;
    localparam int HOLD_W = $clog2(HOLD_CYC + 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);

    // ----------------------------------------
    // Whole module state
    // ----------------------------------------
    typedef struct packed {
        psm_state_type st;
        logic [HOLD_W-1:0] hold_cnt;
        logic [2:0] new_osc;
        logic [2:0] active_osc;
        logic [2:0] sleep_osc;
        logic [15:0] pmd;
        logic osc_req;
        logic wdt_clr;
        logic woke_sleep;
        logic woke_idle;
        logic woke_wdt;
        logic [N_IRQ-1:0] irq_s1;
        logic [N_IRQ-1:0] irq_s2;
        logic [N_IRQ-1:0] irq_s3;
        logic [N_IRQ-1:0] irq_f;
        logic wdt_s1;
        logic wdt_s2;
        logic wdt_s3;
        logic wdt_f;
        logic [31:0] rdata;
        logic rerr;
        logic cpu_run;
        psm_clk_ctrl_type clk;
        logic [15:0] pclk_en;
    } psm_regs_type;

    psm_regs_type r;
    psm_regs_type next_r;

    logic setup_ph;
    logic access_ph;
    logic wr_osc;
    logic wr_pmd;
    logic wr_stat;
    logic wake_ev;
    logic [15:0] osc_word;
    logic [15:0] stat_word;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Zero wait states: answer in the first access cycle
    assign setup_ph = apb_req.psel & ~apb_req.penable;
    assign access_ph = apb_req.psel & apb_req.penable;
    assign pready = access_ph;
    assign pslverr = access_ph & r.rerr;
    assign prdata = r.rdata;
    assign wr_osc = access_ph & apb_req.pwrite & (apb_req.paddr == `PSM_OSC_OFS);
    assign wr_pmd = access_ph & apb_req.pwrite & (apb_req.paddr == `PSM_PMD_OFS);
    assign wr_stat = access_ph & apb_req.pwrite & (apb_req.paddr == `PSM_STAT_OFS);

    // Enabled, debounced interrupt or watchdog time-out
    assign wake_ev = (|(r.irq_f & irq_enable)) | r.wdt_f;

    // Readback words
    always_comb begin
        osc_word = 16'h0000;
        osc_word[`PSM_NEWOSC_MSB:`PSM_NEWOSC_LSB] = r.new_osc;
        osc_word[`PSM_COSC_MSB:`PSM_COSC_LSB] = r.active_osc;
        osc_word[`PSM_LOCK_BIT] = clk_cfg_locked;
        stat_word = 16'h0000;
        stat_word[`PSM_ST_SLEEP_BIT] = (r.st == PSM_ST_SLEEP);
        stat_word[`PSM_ST_IDLE_BIT] = (r.st == PSM_ST_IDLE);
        stat_word[`PSM_ST_HOLD_BIT] = (r.st == PSM_ST_STARTUP);
        stat_word[`PSM_ST_WSLP_BIT] = r.woke_sleep;
        stat_word[`PSM_ST_WIDL_BIT] = r.woke_idle;
        stat_word[`PSM_ST_WWDT_BIT] = r.woke_wdt;
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_r = r;
        next_r.osc_req = 1'b0;
        next_r.wdt_clr = 1'b0;

        // Three-stage input capture; a change counts once stages two and three agree
        next_r.irq_s1 = irq_pending;
        next_r.irq_s2 = r.irq_s1;
        next_r.irq_s3 = r.irq_s2;
        next_r.irq_f = (r.irq_s2 & r.irq_s3) | (r.irq_f & (r.irq_s2 | r.irq_s3));
        next_r.wdt_s1 = wdt_timeout;
        next_r.wdt_s2 = r.wdt_s1;
        next_r.wdt_s3 = r.wdt_s2;
        next_r.wdt_f = (r.wdt_s2 & r.wdt_s3) | (r.wdt_f & (r.wdt_s2 | r.wdt_s3));

        // Read data captured in the setup cycle
        if (setup_ph) begin
            next_r.rerr = 1'b0;
            case (apb_req.paddr)
                `PSM_OSC_OFS: next_r.rdata = {16'h0000, osc_word};
                `PSM_PMD_OFS: next_r.rdata = {16'h0000, r.pmd};
                `PSM_STAT_OFS: next_r.rdata = {16'h0000, stat_word};
                default: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rerr = 1'b1;
                end
            endcase
        end

        // Oscillator select write, ignored while configuration is locked
        if (wr_osc && !clk_cfg_locked) begin
            next_r.new_osc = apb_req.pwdata[`PSM_NEWOSC_MSB:`PSM_NEWOSC_LSB];
            next_r.active_osc = apb_req.pwdata[`PSM_NEWOSC_MSB:`PSM_NEWOSC_LSB];
            next_r.osc_req = 1'b1;
        end

        // Module disable bits; unimplemented bits stay zero
        if (wr_pmd) begin
            next_r.pmd = apb_req.pwdata[15:0] & `PSM_PMD_MASK;
        end

        // Write one to clear wake flags
        if (wr_stat) begin
            if (apb_req.pwdata[`PSM_ST_WSLP_BIT]) begin
                next_r.woke_sleep = 1'b0;
            end
            if (apb_req.pwdata[`PSM_ST_WIDL_BIT]) begin
                next_r.woke_idle = 1'b0;
            end
            if (apb_req.pwdata[`PSM_ST_WWDT_BIT]) begin
                next_r.woke_wdt = 1'b0;
            end
        end

        // Power-save sequencer; flag sets come after clears so a set wins
        case (r.st)
            PSM_ST_STARTUP: begin
                // Ends one short, so the hold lasts exactly HOLD_CYC cycles
                if (r.hold_cnt == HOLD_LAST) begin
                    next_r.st = PSM_ST_RUN;
                    next_r.hold_cnt = '0;
                end else begin
                    next_r.hold_cnt = r.hold_cnt + 1'b1;
                end
            end
            PSM_ST_RUN: begin
                if (psave_valid) begin
                    if (psave_op == PSM_OP_SLEEP) begin
                        next_r.st = PSM_ST_ENTER_SLEEP;
                        next_r.wdt_clr = wdt_enabled;
                        next_r.sleep_osc = r.active_osc;
                    end else begin
                        next_r.st = PSM_ST_IDLE;
                    end
                end
            end
            PSM_ST_ENTER_SLEEP: begin
                next_r.st = PSM_ST_SLEEP;
            end
            PSM_ST_SLEEP: begin
                if (wake_ev) begin
                    next_r.st = PSM_ST_STARTUP;
                    next_r.hold_cnt = '0;
                    next_r.active_osc = r.sleep_osc;
                    next_r.woke_sleep = 1'b1;
                    // Sticky: a later wake without time-out keeps it
                    next_r.woke_wdt = r.woke_wdt | r.wdt_f;
                end
            end
            PSM_ST_IDLE: begin
                if (wake_ev) begin
                    next_r.st = PSM_ST_RUN;
                    next_r.woke_idle = 1'b1;
                    next_r.woke_wdt = r.woke_wdt | r.wdt_f;
                end
            end
            default: begin
                next_r.st = PSM_ST_STARTUP;
                next_r.hold_cnt = '0;
            end
        endcase

        // Clock and run enables follow the next state
        next_r.cpu_run = 1'b0;
        next_r.clk.cpu_clk_en = 1'b1;
        next_r.clk.sys_osc_en = 1'b1;
        next_r.clk.fscm_en = 1'b1;
        next_r.clk.rc_clk_en = 1'b1;
        next_r.pclk_en = ~next_r.pmd;
        case (next_r.st)
            PSM_ST_STARTUP: begin
                // Core held off while the supply settles
                next_r.cpu_run = 1'b0;
            end
            PSM_ST_RUN: begin
                next_r.cpu_run = 1'b1;
            end
            PSM_ST_ENTER_SLEEP: begin
                // Core stopped; oscillator up one more cycle
                next_r.cpu_run = 1'b0;
            end
            PSM_ST_SLEEP: begin
                // Everything on the system clock stops
                next_r.clk.cpu_clk_en = 1'b0;
                next_r.clk.sys_osc_en = 1'b0;
                next_r.clk.fscm_en = 1'b0;
                next_r.clk.rc_clk_en = wdt_enabled;
                next_r.pclk_en = ~next_r.pmd & EXT_CLK_OK;
            end
            PSM_ST_IDLE: begin
                // Modules keep their clocks, the core does not
                next_r.clk.cpu_clk_en = 1'b0;
            end
            default: begin
                next_r.cpu_run = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            r.st <= PSM_ST_STARTUP;
            r.hold_cnt <= '0;
            r.new_osc <= `PSM_OSC_RST;
            r.active_osc <= `PSM_OSC_RST;
            r.sleep_osc <= `PSM_OSC_RST;
            r.pmd <= `PSM_PMD_RST;
            r.osc_req <= 1'b0;
            r.wdt_clr <= 1'b0;
            r.woke_sleep <= 1'b0;
            r.woke_idle <= 1'b0;
            r.woke_wdt <= 1'b0;
            r.irq_s1 <= '0;
            r.irq_s2 <= '0;
            r.irq_s3 <= '0;
            r.irq_f <= '0;
            r.wdt_s1 <= 1'b0;
            r.wdt_s2 <= 1'b0;
            r.wdt_s3 <= 1'b0;
            r.wdt_f <= 1'b0;
            r.rdata <= 32'h0000_0000;
            r.rerr <= 1'b0;
            r.cpu_run <= 1'b0;
            r.clk <= 4'hf;
            r.pclk_en <= 16'hffff;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign cpu_run = r.cpu_run;
    assign clk_ctrl = r.clk;
    assign wdt_clear = r.wdt_clr;
    assign osc_switch_req = r.osc_req;
    assign sys_osc_sel = r.active_osc;
    assign periph_clk_en = r.pclk_en;
    assign periph_hold = r.pmd;

endmodule // psm_power_save_ctrl

// ==== bench/psm_ctrl_monitor.sv ====
// Port checker for the power-save controller
`timescale 1ns/1ps
module psm_ctrl_monitor
    import psm_pkg::*;
#(
    parameter int N_IRQ = 8,
    parameter logic [15:0] EXT_CLK_OK = 16'h0000
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire psm_apb_req_type apb_req,
    input wire logic psave_valid,
    input wire psm_op_type psave_op,
    input wire logic [N_IRQ-1:0] irq_pending,
    input wire logic [N_IRQ-1:0] irq_enable,
    input wire logic wdt_timeout,
    input wire logic wdt_enabled,
    input wire logic clk_cfg_locked,
    input wire logic cpu_run,
    input wire psm_clk_ctrl_type clk_ctrl,
    input wire logic wdt_clear,
    input wire logic osc_switch_req,
    input wire logic [2:0] sys_osc_sel,
    input wire logic [15:0] periph_clk_en,
    input wire logic [15:0] periph_hold
);
    logic [11:0] up_cnt;
    logic [3:0] quiet;
    wire logic take = psave_valid && cpu_run;
    wire logic slp = take && psave_op == PSM_OP_SLEEP;
    wire logic wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    // Cycles since reset release, and cycles with no wake cause
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            up_cnt <= '0;
        end else if (up_cnt != 12'hfff) begin
            up_cnt <= up_cnt + 12'h001;
        end
        if (!rst_n || (irq_pending & irq_enable) != '0 || wdt_timeout) begin
            quiet <= '0;
        end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_IDLE: assert property (take && psave_op == PSM_OP_IDLE |=> !cpu_run
        && !clk_ctrl.cpu_clk_en && periph_clk_en == $past(periph_clk_en)) else $error("idle entry");
    AST_SLEEP: assert property (slp |-> ##2 !clk_ctrl.sys_osc_en && !clk_ctrl.fscm_en
        && !clk_ctrl.cpu_clk_en) else $error("sleep clocks");
    AST_LOW_POWER_RC_CLOCK: assert property (slp |-> ##2 clk_ctrl.rc_clk_en == $past(wdt_enabled))
        else $error("rc clock in sleep");
    AST_WDTCLR: assert property (slp |=> wdt_clear == $past(wdt_enabled))
        else $error("watchdog clear");
    AST_PERIPH: assert property (slp |-> ##2 periph_clk_en == (~periph_hold & EXT_CLK_OK))
        else $error("sleep module clocks");
    AST_ENTRY: assert property ($fell(cpu_run) |-> $past(psave_valid))
        else $error("run left without instruction");
    AST_NOWAKE: assert property (!clk_ctrl.sys_osc_en && quiet > 4'h6 |=> !clk_ctrl.sys_osc_en)
        else $error("wake without cause");
    AST_HOLD_LO: assert property (up_cnt < 12'h7cb |-> !cpu_run) else $error("hold too short");
    AST_HOLD_HI: assert property (up_cnt == 12'h7d5 |-> cpu_run) else $error("hold too long");
    AST_OSC: assert property (wr && apb_req.paddr == 8'h00 && !clk_cfg_locked |-> ##[1:2]
        osc_switch_req) else $error("no switch request");
    AST_OSC_SEL: assert property (wr && apb_req.paddr == 8'h00 && !clk_cfg_locked |-> ##2
        sys_osc_sel == $past(apb_req.pwdata[10:8], 2)) else $error("select not taken");
    AST_PMD: assert property (wr && apb_req.paddr == 8'h04 |-> ##2
        periph_hold == ($past(apb_req.pwdata[15:0], 2) & 16'hf9ff)) else $error("disable bits");
endmodule // psm_ctrl_monitor

bind psm_power_save_ctrl psm_ctrl_monitor #(.N_IRQ(N_IRQ), .EXT_CLK_OK(EXT_CLK_OK)) mon_u (
    .ref_clk, .rst_n, .apb_req, .psave_valid, .psave_op, .irq_pending, .irq_enable,
    .wdt_timeout, .wdt_enabled, .clk_cfg_locked, .cpu_run, .clk_ctrl, .wdt_clear,
    .osc_switch_req, .sys_osc_sel, .periph_clk_en, .periph_hold);

// ==== bench/psm_core_model.sv ====
// Core model that issues the power-save instruction
`timescale 1ns/1ps
module psm_core_model
    import psm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cpu_run,
    input wire logic go,
    input wire psm_op_type op,
    output logic psave_valid,
    output psm_op_type psave_op
);
    logic pend;
    // One pulse per request, only while executing; operand churns otherwise
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pend <= 1'b0;
            psave_valid <= 1'b0;
            psave_op <= PSM_OP_SLEEP;
        end else begin
            psave_valid <= (pend || go) && cpu_run;
            pend <= (pend || go) && !cpu_run;
            psave_op <= (pend || go) ? op : psm_op_type'(~psave_op);
        end
    end
endmodule // psm_core_model

// ==== bench/psm_power_save_ctrl_test.sv ====
// Self-checking bench for the power-save controller
`timescale 1ns/1ps
module psm_power_save_ctrl_test
    import psm_pkg::*;
();
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    psm_apb_req_type req = '0;
    logic go = 1'b0;
    psm_op_type op = PSM_OP_SLEEP;
    logic [7:0] irq_p = 8'h00;
    logic [7:0] irq_e = 8'h00;
    logic wto = 1'b0;
    logic wen = 1'b0;
    logic lck = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, pv, cpu_run, osr;
    psm_op_type pop;
    psm_clk_ctrl_type cc;
    logic [2:0] osel;
    logic [15:0] pce, phold;
    int bad_count = 0;
    int cmp_count = 0;
    psm_power_save_ctrl #(.N_IRQ(8), .EXT_CLK_OK(16'h0030)) dut_u (.ref_clk, .rst_n,
        .apb_req(req), .prdata, .pready, .pslverr, .psave_valid(pv), .psave_op(pop),
        .irq_pending(irq_p), .irq_enable(irq_e), .wdt_timeout(wto), .wdt_enabled(wen),
        .clk_cfg_locked(lck), .cpu_run, .clk_ctrl(cc), .wdt_clear(), .osc_switch_req(osr),
        .sys_osc_sel(osel), .periph_clk_en(pce), .periph_hold(phold));
    psm_core_model core_u (.ref_clk, .rst_n, .cpu_run, .go, .op, .psave_valid(pv),
        .psave_op(pop));
    // ----------------------------------------
    // Clock and shared tasks
    // ----------------------------------------
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        req <= '0;
    endtask
    task automatic wait_run(input int lim);
        int n;
        n = 0;
        while (cpu_run !== 1'b1 && n < lim) begin
            look(1);
            n++;
        end
        chk("cpu run", cpu_run, 1'b1);
    endtask
    task automatic save(input psm_op_type o);
        @(posedge ref_clk);
        op <= o;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk("disable reset", r, 32'h0);
        apb(1'b1, 8'h04, 32'hffffffff, r, e);
        apb(1'b0, 8'h04, 32'h0, r, e);
        chk("disable map", r, 32'h0000f9ff);
        look(2);
        chk("hold", phold, 16'hf9ff);
        chk("gated", pce & 16'hf9ff, 16'h0000);
        apb(1'b1, 8'h04, 32'h0, r, e);
        apb(1'b0, 8'h0c, 32'h0, r, e);
        chk("unmapped err", e, 1'b1);
        chk("unmapped data", r, 32'h0);
        apb(1'b1, 8'h00, 32'h00000300, r, e);
        #1;
        chk("switch req", osr, 1'b1);
        look(2);
        chk("osc sel", osel, 3'h3);
        @(posedge ref_clk);
        lck <= 1'b1;
        apb(1'b1, 8'h00, 32'h00000500, r, e);
        #1;
        chk("locked req", osr, 1'b0);
        look(2);
        chk("locked sel", osel, 3'h3);
        @(posedge ref_clk);
        lck <= 1'b0;
        $display("registers done");
    endtask
    task automatic t_idle();
        @(posedge ref_clk);
        irq_e <= 8'h01;
        save(PSM_OP_IDLE);
        look(4);
        chk("idle run", cpu_run, 1'b0);
        chk("idle cpu clk", cc.cpu_clk_en, 1'b0);
        chk("idle modules", pce & 16'hf9ff, 16'hf9ff);
        @(posedge ref_clk);
        irq_p <= 8'h01;
        wait_run(20);
        @(posedge ref_clk);
        irq_p <= 8'h00;
        $display("idle done");
    endtask
    task automatic t_sleep();
        logic [31:0] r;
        logic e;
        @(posedge ref_clk);
        wen <= 1'b1;
        apb(1'b1, 8'h04, 32'h00000010, r, e);
        save(PSM_OP_SLEEP);
        look(4);
        chk("osc off", cc.sys_osc_en, 1'b0);
        chk("monitor off", cc.fscm_en, 1'b0);
        chk("rc on", cc.rc_clk_en, 1'b1);
        chk("sleep modules", pce, 16'h0020);
        @(posedge ref_clk);
        irq_p <= 8'h02;
        apb(1'b1, 8'h00, 32'h00000500, r, e);
        look(20);
        chk("masked irq", cc.sys_osc_en, 1'b0);
        @(posedge ref_clk);
        wto <= 1'b1;
        wait_run(2200);
        chk("osc kept", osel, 3'h3);
        @(posedge ref_clk);
        wto <= 1'b0;
        irq_p <= 8'h00;
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk("wake flags", r, 32'h00000070);
        apb(1'b1, 8'h08, 32'h00000070, r, e);
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk("flags cleared", r, 32'h0);
        apb(1'b1, 8'h04, 32'h0, r, e);
        $display("sleep done");
    endtask
    task automatic t_rst();
        save(PSM_OP_IDLE);
        look(4);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_run(2100);
        chk("reset osc", osel, 3'h0);
        $display("reset wake done");
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        look(1990);
        chk("start hold", cpu_run, 1'b0);
        wait_run(30);
        t_regs();
        t_idle();
        t_sleep();
        t_rst();
        end_of_test();
    end
    // Watchdog against a hang
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
endmodule // psm_power_save_ctrl_test
